// ---- rtl/charge_port_regs.svh ----
// Purpose: register offsets, fields, reset values and timing counts
// Assumes: 32-bit AXI4-Lite register words, 100 MHz clock
// Notes:   included by bare name
`ifndef CHARGE_PORT_REGS_SVH
`define CHARGE_PORT_REGS_SVH

`define CLK_PERIOD_NS       32'd10
`define DEBOUNCE_TIME_US    32'd150
`define DEBOUNCE_CYCLES     ((`DEBOUNCE_TIME_US * 32'd1000) / `CLK_PERIOD_NS)
`define PULSE_1V2_TIME_US   32'd100
`define PULSE_1V2_CYCLES    ((`PULSE_1V2_TIME_US * 32'd1000) / `CLK_PERIOD_NS)

`define REG_CTRL            4'h0
`define REG_STATUS          4'h4
`define REG_DCP_STATE       4'h8

`define CTRL_SOFT_EN_BIT    0
`define CTRL_DCP_VARIANT    1
`define CTRL_RESET          32'h0000_0001

`define ST_ATTACHED_BIT     0
`define ST_VCONN_CC1_BIT    1
`define ST_VCONN_CC2_BIT    2
`define ST_SWITCH_BIT       3
`define ST_MODE_LSB         4

`endif

// ---- rtl/charge_port_pkg.sv ----
// Purpose: shared types of the charge port mode control
// Assumes: none
// Notes:   constants live in charge_port_regs.svh
package charge_port_pkg;

   typedef enum logic [2:0]
   {
      PORT_OFF      = 3'b000,
      PORT_STANDBY  = 3'b001,
      PORT_DEBOUNCE = 3'b011,
      PORT_ATTACHED = 3'b010,
      PORT_RELEASE  = 3'b110
   } port_state_e;

   typedef enum logic [1:0]
   {
      USB_TYPEC = 2'b00,
      USB_SDP   = 2'b01,
      USB_CDP   = 2'b11,
      USB_DCP   = 2'b10
   } usb_mode_e;

   typedef enum logic [1:0]
   {
      DCP_DIVIDER3 = 2'b00,
      DCP_ONE_V2   = 2'b01,
      DCP_SHORTED  = 2'b11
   } dcp_state_e;

endpackage : charge_port_pkg

// ---- rtl/charge_port_mode_ctrl.sv ----
// Purpose: mode control of a Type-C charging port
// Assumes: analog comparators deliver levels; all front-end pins are asynchronous
// Notes:   registers over AXI4-Lite, answer two cycles after request
//
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ns
`include "charge_port_regs.svh"

// Notes on behaviour
// R01 - sample enable once supply above lockout
// R02 - after start-up, watch both CC pins
// R03 - regulator on only after attach debounce
// R04 - drive load-switch gate after debounced attach
// R05 - VCONN to the pin showing Ra
// R06 - start Type-C, then select SDP/CDP/DCP
// R07 - sink drives D+ first, senses D-
// R08 - sink drives D- second, senses D+
// R09 - one DCP-auto state runs detection machine
// R10 - shorted mode ties D+ to D-
// R11 - divider-3 drives 2.7 V on both lines
// R12 - 1.2 V shorted pull-up, timed, then shorted
// R13 - detection machine starts in divider-3
// R14 - shorted-compliant sink passes through 1.2 V
// R15 - stay until line released, back to divider-3
// R16 - divider-3 sink keeps divider-3 state
// R17 - pass switches closed in CDP and SDP
// R18 - switches need enable and attached state
// R19 - CDP keeps switches closed during handshake
// R20 - FET current limit opens switches
// R21 - VCONN current limit leaves switches closed
// R22 - mode pins: 10 SDP, 11 CDP, 01 DCP when ctrl dcp_variant bit set, else Type-C
// R23 - idle low power, regulator off until Rd
// R24 - debounce counter restarts on attach drop
// R25 - switch enable is AND of conditions
module charge_port_mode_ctrl #(
   parameter int DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES,
   parameter int PULSE_CYCLES    = `PULSE_1V2_CYCLES
)(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // analog front end levels
   input  wire logic        supply_ok,
   input  wire logic        enable_undervoltage_input,
   input  wire logic        cc1_rd,
   input  wire logic        cc2_rd,
   input  wire logic        cc1_ra,
   input  wire logic        cc2_ra,
   input  wire logic        mode_select_1,
   input  wire logic        mode_select_2,
   input  wire logic        dplus_driven,
   input  wire logic        fet_ilim,
   input  wire logic        vconn_ilim,
   // power and data path controls
   output logic             regulator_en,
   output logic             load_switch_gate_drive,
   output logic             vconn_cc1,
   output logic             vconn_cc2,
   output logic             data_switch_en,
   output logic             dcp_short_en,
   output logic             dcp_divider_en,
   output logic             dcp_1v2_en,
   // axi4-lite slave
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   //-------------------------------------------------------------
   // input synchronisers
   //-------------------------------------------------------------
   localparam int NSYNC = 11;
   logic [NSYNC-1:0] sync_a;
   logic [NSYNC-1:0] sync_b;
   wire  [NSYNC-1:0] pins = {vconn_ilim, fet_ilim, dplus_driven,
                             mode_select_2, mode_select_1, cc2_ra, cc1_ra,
                             cc2_rd, cc1_rd, enable_undervoltage_input,
                             supply_ok};
   always_ff @(posedge clk)
   begin
      sync_a <= pins;
      sync_b <= sync_a;
   end
   wire s_supply = sync_b[0];
   wire s_en     = sync_b[1];
   wire s_rd1    = sync_b[2];
   wire s_rd2    = sync_b[3];
   wire s_ra1    = sync_b[4];
   wire s_ra2    = sync_b[5];
   wire s_ms1    = sync_b[6];
   wire s_ms2    = sync_b[7];
   wire s_dline  = sync_b[8];
   wire s_filim  = sync_b[9];
   wire s_vilim  = sync_b[10];

   //-------------------------------------------------------------
   // registers
   //-------------------------------------------------------------
   logic [1:0] ctrl;
   wire soft_en     = ctrl[`CTRL_SOFT_EN_BIT];
   wire dcp_variant = ctrl[`CTRL_DCP_VARIANT];

   //-------------------------------------------------------------
   // attach state machine
   //-------------------------------------------------------------
   charge_port_pkg::port_state_e state;
   charge_port_pkg::port_state_e next_state;
   logic [31:0] deb_cnt;
   logic        cc1_is_sink;
   wire enabled = s_supply & s_en & soft_en;                  // R01
   wire any_rd  = s_rd1 | s_rd2;                              // R02
   wire deb_done = (deb_cnt >= 32'(DEBOUNCE_CYCLES - 1));
   wire attached = (state == charge_port_pkg::PORT_ATTACHED);

   always_comb
   begin
      next_state = state;
      case (state)
         charge_port_pkg::PORT_OFF:
            if (enabled)
               next_state = charge_port_pkg::PORT_STANDBY;    // R01
         charge_port_pkg::PORT_STANDBY:
            if (!enabled)
               next_state = charge_port_pkg::PORT_OFF;
            else if (any_rd)
               next_state = charge_port_pkg::PORT_DEBOUNCE;   // R23
         charge_port_pkg::PORT_DEBOUNCE:
            if (!enabled)
               next_state = charge_port_pkg::PORT_OFF;
            else if (!any_rd)
               next_state = charge_port_pkg::PORT_STANDBY;    // R24
            else if (deb_done)
               next_state = charge_port_pkg::PORT_ATTACHED;   // R03
         charge_port_pkg::PORT_ATTACHED:
            if (!enabled || !any_rd)
               next_state = charge_port_pkg::PORT_RELEASE;
         charge_port_pkg::PORT_RELEASE:
            next_state = enabled ? charge_port_pkg::PORT_STANDBY
                                 : charge_port_pkg::PORT_OFF;
         default:
            next_state = charge_port_pkg::PORT_OFF;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         state <= charge_port_pkg::PORT_OFF;
      else
         state <= next_state;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst || state != charge_port_pkg::PORT_DEBOUNCE || !any_rd)
         deb_cnt <= 32'd0;                                    // R24
      else if (!deb_done)
         deb_cnt <= deb_cnt + 32'd1;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         cc1_is_sink <= 1'b1;
      else if (state == charge_port_pkg::PORT_DEBOUNCE)
         cc1_is_sink <= s_rd1;
   end

   //-------------------------------------------------------------
   // usb mode decode
   //-------------------------------------------------------------
   charge_port_pkg::usb_mode_e mode;
   wire pins_sdp = s_ms1 & ~s_ms2;                            // R22
   wire pins_cdp = s_ms1 & s_ms2;                             // R22
   wire pins_dcp = ~s_ms1 & s_ms2 & dcp_variant;              // R22
   charge_port_pkg::usb_mode_e next_mode;
   assign next_mode = !attached ? charge_port_pkg::USB_TYPEC :  // R06
                      pins_sdp  ? charge_port_pkg::USB_SDP :
                      pins_cdp  ? charge_port_pkg::USB_CDP :
                      pins_dcp  ? charge_port_pkg::USB_DCP :
                                  charge_port_pkg::USB_TYPEC;
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         mode <= charge_port_pkg::USB_TYPEC;
      else
         mode <= next_mode;
   end

   //-------------------------------------------------------------
   // dcp auto-detect machine
   //-------------------------------------------------------------
   charge_port_pkg::dcp_state_e dcp;
   charge_port_pkg::dcp_state_e next_dcp;
   logic [31:0] pulse_cnt;
   wire in_dcp = (mode == charge_port_pkg::USB_DCP);          // R09
   always_comb
   begin
      next_dcp = dcp;
      case (dcp)
         charge_port_pkg::DCP_DIVIDER3:
            if (s_dline)
               next_dcp = charge_port_pkg::DCP_ONE_V2;        // R14
         charge_port_pkg::DCP_ONE_V2:
            if (!s_dline)
               next_dcp = charge_port_pkg::DCP_DIVIDER3;      // R15
            else if (pulse_cnt >= 32'(PULSE_CYCLES - 1))
               next_dcp = charge_port_pkg::DCP_SHORTED;       // R12
         charge_port_pkg::DCP_SHORTED:
            if (!s_dline)
               next_dcp = charge_port_pkg::DCP_DIVIDER3;      // R15
         default:
            next_dcp = charge_port_pkg::DCP_DIVIDER3;
      endcase
      if (!in_dcp)
         next_dcp = charge_port_pkg::DCP_DIVIDER3;            // R13
   end
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         dcp <= charge_port_pkg::DCP_DIVIDER3;                // R13
      else
         dcp <= next_dcp;
   end
   always_ff @(posedge clk)
   begin
      if (sys_rst || dcp != charge_port_pkg::DCP_ONE_V2)
         pulse_cnt <= 32'd0;
      else
         pulse_cnt <= pulse_cnt + 32'd1;
   end

   //-------------------------------------------------------------
   // output drive
   //-------------------------------------------------------------
   wire next_sw = s_en & attached & ~s_filim &                // R25 R20
      (mode == charge_port_pkg::USB_CDP ||                    // R19
       mode == charge_port_pkg::USB_SDP);                     // R17 R18 R21
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         regulator_en           <= 1'b0;
         load_switch_gate_drive <= 1'b0;
         vconn_cc1              <= 1'b0;
         vconn_cc2              <= 1'b0;
         data_switch_en         <= 1'b0;
         dcp_short_en           <= 1'b0;
         dcp_divider_en         <= 1'b0;
         dcp_1v2_en             <= 1'b0;
      end
      else
      begin
         regulator_en           <= attached;                  // R03 R23
         load_switch_gate_drive <= attached;                  // R04
         vconn_cc1              <= attached & ~cc1_is_sink & s_ra1; // R05
         vconn_cc2              <= attached & cc1_is_sink & s_ra2;  // R05
         data_switch_en         <= next_sw;
         dcp_short_en           <= in_dcp &
            (dcp != charge_port_pkg::DCP_DIVIDER3);           // R10 R12
         dcp_divider_en         <= in_dcp &
            (dcp == charge_port_pkg::DCP_DIVIDER3);           // R11 R16
         dcp_1v2_en             <= in_dcp &
            (dcp == charge_port_pkg::DCP_ONE_V2);             // R12
      end
   end

   //-------------------------------------------------------------
   // axi4-lite slave
   //-------------------------------------------------------------
   wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   wire rd_go = s_axi_arvalid & ~s_axi_rvalid;
   // answer only once address and data handshakes have completed
   wire wr_done = wr_go & s_axi_awready & s_axi_wready;
   wire rd_done = rd_go & s_axi_arready;
   wire wr_ctrl = wr_done & (s_axi_awaddr == `REG_CTRL) & s_axi_wstrb[0];
   wire aw_ok = (s_axi_awaddr == `REG_CTRL);
   wire [31:0] status_word = {26'h0, 2'(mode), data_switch_en,
                              vconn_cc2, vconn_cc1, attached};
   wire ar_ok = (s_axi_araddr == `REG_CTRL) ||
                (s_axi_araddr == `REG_STATUS) ||
                (s_axi_araddr == `REG_DCP_STATE);
   wire [31:0] rd_word =
      (s_axi_araddr == `REG_CTRL)   ? {30'h0, ctrl} :
      (s_axi_araddr == `REG_STATUS) ? status_word :
      (s_axi_araddr == `REG_DCP_STATE) ? {30'h0, 2'(dcp)} : 32'h0;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         ctrl <= 2'(`CTRL_RESET);
      else if (wr_ctrl)
         ctrl <= s_axi_wdata[1:0];
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= 2'h0;
         s_axi_rdata   <= 32'h0;
      end
      else
      begin
         s_axi_awready <= wr_go & ~s_axi_awready;
         s_axi_wready  <= wr_go & ~s_axi_awready;
         if (wr_done)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= aw_ok ? 2'h0 : 2'h2;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
         s_axi_arready <= rd_go & ~s_axi_arready;
         if (rd_done)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= ar_ok ? 2'h0 : 2'h2;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   //-------------------------------------------------------------
   // assertions
   //-------------------------------------------------------------
   property p_reg_after_attach;
      @(posedge clk) disable iff (sys_rst)
      $rose(regulator_en) |-> $past(state) == charge_port_pkg::PORT_ATTACHED;
   endproperty
   a_reg_after_attach: assert property (p_reg_after_attach) // R03
      else $error("regulator on without attach");

   property p_gate_follows_reg;
      @(posedge clk) disable iff (sys_rst)
      (load_switch_gate_drive == regulator_en) &&
      (load_switch_gate_drive == $past(attached));
   endproperty
   a_gate_follows_reg: assert property (p_gate_follows_reg) // R04
      else $error("gate drive differs from regulator");

   property p_fet_ilim_opens;
      @(posedge clk) disable iff (sys_rst)
      s_filim |=> !data_switch_en;
   endproperty
   a_fet_ilim_opens: assert property (p_fet_ilim_opens) // R20
      else $error("switch closed in fet limit");

   property p_vconn_ilim_keeps;
      @(posedge clk) disable iff (sys_rst)
      (s_vilim && next_sw) |=> data_switch_en;
   endproperty
   a_vconn_ilim_keeps: assert property (p_vconn_ilim_keeps) // R21
      else $error("switch opened in vconn limit");

   property p_switch_needs_attach;
      @(posedge clk) disable iff (sys_rst)
      !attached |=> !data_switch_en;
   endproperty
   a_switch_needs_attach: assert property (p_switch_needs_attach) // R18
      else $error("switch closed while detached");

   property p_debounce_len;
      @(posedge clk) disable iff (sys_rst)
      $rose(attached) |-> deb_cnt == 32'(DEBOUNCE_CYCLES - 1);
   endproperty
   a_debounce_len: assert property (p_debounce_len) // R24
      else $error("attach before debounce elapsed");

   property p_dcp_start;
      @(posedge clk) disable iff (sys_rst)
      !in_dcp |=> dcp == charge_port_pkg::DCP_DIVIDER3;
   endproperty
   a_dcp_start: assert property (p_dcp_start) // R13
      else $error("dcp machine not in divider-3");

   property p_release_back;
      @(posedge clk) disable iff (sys_rst)
      (dcp == charge_port_pkg::DCP_SHORTED && !s_dline)
         |=> dcp == charge_port_pkg::DCP_DIVIDER3;
   endproperty
   a_release_back: assert property (p_release_back) // R15
      else $error("no return to divider-3");

   property p_vconn_exclusive;
      @(posedge clk) disable iff (sys_rst)
      !(vconn_cc1 && vconn_cc2);
   endproperty
   a_vconn_exclusive: assert property (p_vconn_exclusive) // R05
      else $error("vconn on both pins");

   c_attach: cover property (@(posedge clk) $rose(attached));
   c_shorted: cover property (@(posedge clk)
      dcp == charge_port_pkg::DCP_SHORTED);
   c_switch: cover property (@(posedge clk) $rose(data_switch_en));

endmodule : charge_port_mode_ctrl

// ---- verification/usb_sink_model.sv ----
// Purpose: behavioural sink device and cable seen at the port pins
// Assumes: levels change just after a rising clock edge
// Notes:   a released line falls to 0, meaning no Rd or Ra present
`timescale 1ns/1ns
module usb_sink_model (
   // clock
   input  wire logic clk,
   // scenario controls
   input  wire logic attach,
   input  wire logic flip,
   input  wire logic cable,
   input  wire logic shorted_sink,
   input  wire logic bounce,
   // pin levels seen by the port
   output logic      cc1_rd       = 1'b0,
   output logic      cc2_rd       = 1'b0,
   output logic      cc1_ra       = 1'b0,
   output logic      cc2_ra       = 1'b0,
   output logic      dplus_driven = 1'b0
);
   logic [3:0] age = 4'h0;
   logic       rd_now;

   // one-cycle contact bounce four cycles after plug-in
   assign rd_now = attach && !(bounce && age == 4'h4);

   always_ff @(posedge clk)
   begin
      if (!attach)
         age <= 4'h0;
      else if (age != 4'hF)
         age <= age + 4'h1;
      cc1_rd       <= rd_now && !flip;
      cc2_rd       <= rd_now && flip;
      cc1_ra       <= attach && cable && flip;
      cc2_ra       <= attach && cable && !flip;
      dplus_driven <= attach && shorted_sink;
   end
endmodule : usb_sink_model

// ---- verification/usb_charge_port_mode_control_tb.sv ----
// Purpose: self-checking bench of the charge port mode control
// Assumes: debounce and 1.2 V counts shortened to 8 cycles
// Notes:   register and supply checks first, then mode table, then random attach cases, seed 45
`timescale 1ns/1ns
`include "charge_port_regs.svh"
module usb_charge_port_mode_control_tb;
   localparam int DEB = 8;
   localparam int PUL = 8;
   logic              clk = 1'b0;
   logic              sys_rst, supply_ok, enable_undervoltage_input;
   logic              mode_select_1, mode_select_2, fet_ilim, vconn_ilim;
   logic              attach, flip, cable, shorted_sink, bounce;
   wire logic         cc1_rd, cc2_rd, cc1_ra, cc2_ra, dplus_driven;
   wire logic         regulator_en, load_switch_gate_drive;
   wire logic         vconn_cc1, vconn_cc2, data_switch_en;
   wire logic         dcp_short_en, dcp_divider_en, dcp_1v2_en;
   logic [3:0]        s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0]       s_axi_wdata;
   logic              s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic              s_axi_arvalid, s_axi_rready;
   wire logic         s_axi_awready, s_axi_wready, s_axi_bvalid;
   wire logic         s_axi_arready, s_axi_rvalid;
   wire logic [1:0]   s_axi_bresp, s_axi_rresp;
   wire logic [31:0]  s_axi_rdata;
   int                num_errors = 0;
   int                n_tests = 0;

   always #5 clk = ~clk;

   usb_sink_model i_sink (.clk, .attach, .flip, .cable, .shorted_sink,
      .bounce, .cc1_rd, .cc2_rd, .cc1_ra, .cc2_ra, .dplus_driven);

   charge_port_mode_ctrl #(.DEBOUNCE_CYCLES(DEB), .PULSE_CYCLES(PUL)) i_dut (
      .clk, .sys_rst, .supply_ok, .enable_undervoltage_input,
      .cc1_rd, .cc2_rd, .cc1_ra, .cc2_ra, .mode_select_1, .mode_select_2,
      .dplus_driven, .fet_ilim, .vconn_ilim, .regulator_en,
      .load_switch_gate_drive, .vconn_cc1, .vconn_cc2, .data_switch_en,
      .dcp_short_en, .dcp_divider_en, .dcp_1v2_en,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         $display("wrong value %s expected %0h seen %0h", what, exp, seen);
         num_errors++;
      end
   endtask : check

   task automatic close_out;
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : close_out

   function automatic charge_port_pkg::usb_mode_e exp_mode(
      input logic a, input logic b, input logic v);
      case ({a, b})
         2'b10:   exp_mode = charge_port_pkg::USB_SDP;
         2'b11:   exp_mode = charge_port_pkg::USB_CDP;
         2'b01:   exp_mode = v ? charge_port_pkg::USB_DCP
                               : charge_port_pkg::USB_TYPEC;
         default: exp_mode = charge_port_pkg::USB_TYPEC;
      endcase
   endfunction : exp_mode

   function automatic logic pick(input int s);
      case (s)
         0:       pick = regulator_en;
         1:       pick = dcp_1v2_en;
         default: pick = dcp_divider_en;
      endcase
   endfunction : pick

   task automatic wait_for(input int s, input logic lvl, output int n);
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pick(s) !== lvl && n < 60);
   endtask : wait_for

   task automatic axi_write(input logic [3:0] a, input logic [31:0] d,
                            input logic [3:0] st, input logic [1:0] er);
      int n;
      n = 0;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
         if (s_axi_awready === 1'b1)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1)
            s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1 && n < 50);
      s_axi_bready <= 1'b0;
      check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
      @(posedge clk);
   endtask : axi_write

   task automatic axi_read(input logic [3:0] a, input logic [31:0] ed,
                           input logic [1:0] er);
      int n;
      n = 0;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
         if (s_axi_arready === 1'b1)
            s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1 && n < 50);
      s_axi_rready <= 1'b0;
      check("rdata", s_axi_rdata, ed);
      check("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
      @(posedge clk);
   endtask : axi_read

   task automatic run_case(input logic a, input logic b, input logic v,
                           input logic f, input logic c, input logic bn);
      int                         n;
      logic                       sw;
      charge_port_pkg::usb_mode_e md;
      md = exp_mode(a, b, v);
      sw = md == charge_port_pkg::USB_SDP || md == charge_port_pkg::USB_CDP;
      axi_write(`REG_CTRL, {30'h0, v, 1'b1}, 4'hF, 2'b00);
      mode_select_1 <= a;
      mode_select_2 <= b;
      flip          <= f;
      cable         <= c;
      bounce        <= bn;
      repeat (4) @(posedge clk);
      attach <= 1'b1;
      wait_for(0, 1'b1, n);
      check("debounce", n, DEB + (bn ? 11 : 6));
      repeat (4) @(posedge clk);
      check("gate", load_switch_gate_drive, 1'b1);
      check("vconn1", vconn_cc1, c & f);
      check("vconn2", vconn_cc2, c & ~f);
      check("switch", data_switch_en, sw);
      axi_read(`REG_STATUS, {26'h0, md, sw, c & ~f, c & f, 1'b1}, 2'b00);
      if (sw)
      begin
         fet_ilim <= 1'b1;
         repeat (4) @(posedge clk);
         check("fet_ilim", data_switch_en, 1'b0);
         fet_ilim   <= 1'b0;
         vconn_ilim <= 1'b1;
         repeat (4) @(posedge clk);
         check("vconn_ilim", data_switch_en, 1'b1);
         vconn_ilim <= 1'b0;
      end
      if (md == charge_port_pkg::USB_DCP)
      begin
         check("div3", {dcp_divider_en, dcp_1v2_en, dcp_short_en}, 3'b100);
         shorted_sink <= 1'b1;
         wait_for(1, 1'b1, n);
         check("one_v2", {dcp_1v2_en, dcp_short_en}, 2'b11);
         wait_for(1, 1'b0, n);
         check("pulse", n, PUL);
         repeat (20) @(posedge clk);
         check("short", {dcp_short_en, dcp_divider_en}, 2'b10);
         axi_read(`REG_DCP_STATE, 32'h3, 2'b00);
         shorted_sink <= 1'b0;
         wait_for(2, 1'b1, n);
         repeat (20) @(posedge clk);
         check("back_div3", {dcp_divider_en, dcp_short_en}, 2'b10);
      end
      else
         check("no_dcp", {dcp_divider_en, dcp_1v2_en, dcp_short_en}, 3'b000);
      enable_undervoltage_input <= 1'b0;
      repeat (4) @(posedge clk);
      check("en_low", data_switch_en, 1'b0);
      enable_undervoltage_input <= 1'b1;
      attach <= 1'b0;
      wait_for(0, 1'b0, n);
      repeat (4) @(posedge clk);
      check("detach", {regulator_en, vconn_cc1, vconn_cc2}, 3'b000);
      repeat (10) @(posedge clk);
   endtask : run_case

   // -------------------------------------------------------------
   // sequence and watchdog
   // -------------------------------------------------------------
   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors++;
      close_out();
   end

   initial
   begin
      {sys_rst, supply_ok, enable_undervoltage_input} <= 3'b111;
      {mode_select_1, mode_select_2, fet_ilim, vconn_ilim} <= 4'h0;
      {attach, flip, cable, shorted_sink, bounce} <= 5'h00;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b000;
      {s_axi_arvalid, s_axi_rready} <= 2'b00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} <= 12'h000;
      s_axi_wdata <= 32'h0;
      void'($urandom(45));
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      check("idle", {regulator_en, data_switch_en}, 2'b00);
      axi_read(`REG_CTRL, `CTRL_RESET, 2'b00);
      axi_read(4'hC, 32'h0, 2'b10);
      axi_write(4'hC, 32'h3, 4'hF, 2'b10);
      axi_write(`REG_CTRL, 32'h2, 4'h0, 2'b00);
      axi_read(`REG_CTRL, `CTRL_RESET, 2'b00);
      supply_ok <= 1'b0;
      attach    <= 1'b1;
      repeat (40) @(posedge clk);
      check("no_supply", regulator_en, 1'b0);
      attach    <= 1'b0;
      supply_ok <= 1'b1;
      repeat (10) @(posedge clk);
      for (int i = 0; i < 8; i++)
         run_case(i[1], i[0], i[2], 1'($urandom), 1'($urandom), i[0]);
      repeat (6)
         run_case(1'($urandom), 1'($urandom), 1'($urandom),
                  1'($urandom), 1'($urandom), 1'($urandom));
      close_out();
   end
endmodule : usb_charge_port_mode_control_tb
